// file: epsc_top.sv
// Encoder speed matched print scan engine with tracking queue and register slave
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module epsc_top
    import epsc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Pins
    input  wire logic        i_enc,
    input  wire logic        i_trig,
    // Print head and system
    output logic             o_scan,
    output logic             o_printing,
    output logic             o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [3:0]  ctrl_r;         // Mode control
    logic [7:0]  div_r;          // Division factor
    logic [5:0]  vd_r;           // Vertical dots
    logic [4:0]  den_r;          // Ink drop use denominator
    logic [15:0] exc_r;          // Cycles per drop
    logic [15:0] gap_r;          // Internal idle cycles between scans
    logic [7:0]  cols_r;         // Scans per message
    logic [2:0]  imsk_r;         // Interrupt mask

    // Status and bus
    logic [2:0]  ist_r;          // Sticky events
    logic        ack_r;          // Bus answer phase
    logic [31:0] rdata_r;        // Read data
    logic        irq_r;          // Interrupt line

    // Scan timing
    // Cycles one scan takes, before internal mode padding
    logic [27:0] scan_len_r;
    // Demanded scans not yet issued
    logic [3:0]  pend_r;
    // Scan in progress
    logic        busy_r;
    // Cycles left in this scan
    logic [29:0] busy_cnt_r;
    // Idle time since last scan
    logic [15:0] gap_cnt_r;

    // Message and queue
    // Next column to print
    logic [7:0]  col_r;
    // Current scan is the last column
    logic        last_r;
    // Queued prints, head one included
    logic [2:0]  q_r;
    logic        scan_r;         // Scan strobe
    logic        printing_r;     // Message in progress

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs and divider
    logic enc_rise;              // Qualified encoder edge
    logic trig_rise;             // Qualified detector edge
    epsc_div_if div_bus ();

    // Encoder pin
    epsc_sync u_enc_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_pin   (i_enc),
        .o_level (),
        .o_rise  (enc_rise)
    );

    // Detector pin
    epsc_sync u_trig_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_pin   (i_trig),
        .o_level (),
        .o_rise  (trig_rise)
    );

    // Pulse divider
    epsc_div u_div (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .bus   (div_bus)
    );

    assign div_bus.tick   = enc_rise;
    assign div_bus.factor = div_r;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire        req      = i_avs_read | i_avs_write;
    wire        wr_fire  = i_avs_write & ack_r;
    wire        rd_fire  = i_avs_read & ack_r;
    wire [31:0] wd       = i_avs_writedata;
    wire [31:0] bmask    = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                            {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // Write strobes and the event read strobe
    wire        wr_ctrl  = wr_fire & (i_avs_address == ADDR_CTRL);
    wire        wr_div   = wr_fire & (i_avs_address == ADDR_DIV);
    wire        wr_fmt   = wr_fire & (i_avs_address == ADDR_FMT);
    wire        wr_exc   = wr_fire & (i_avs_address == ADDR_EXC);
    wire        wr_gap   = wr_fire & (i_avs_address == ADDR_GAP);
    wire        wr_cols  = wr_fire & (i_avs_address == ADDR_COLS);
    wire        wr_imsk  = wr_fire & (i_avs_address == ADDR_IMSK);
    wire        rd_ist   = rd_fire & (i_avs_address == ADDR_IST);

    // Merged write values per register, unselected lanes keep old contents
    wire [31:0] ctrl_m   = (wd & bmask) | ({28'h0, ctrl_r} & ~bmask);
    wire [31:0] div_m    = (wd & bmask) | ({24'h0, div_r} & ~bmask);
    wire [31:0] fmt_m    = (wd & bmask) | ({19'h0, den_r, 2'h0, vd_r} & ~bmask);
    wire [31:0] exc_m    = (wd & bmask) | ({16'h0, exc_r} & ~bmask);
    wire [31:0] gap_m    = (wd & bmask) | ({16'h0, gap_r} & ~bmask);
    wire [31:0] cols_m   = (wd & bmask) | ({24'h0, cols_r} & ~bmask);
    wire [31:0] imsk_m   = (wd & bmask) | ({29'h0, imsk_r} & ~bmask);

    // Tracking wins when software asks for both at once
    wire [3:0]  ctrl_w   = ctrl_m[3:0] & ~(4'h1 << CTRL_REPEAT) |
                           ((ctrl_m[CTRL_REPEAT] & ~ctrl_m[CTRL_TRACK]) ? (4'h1 << CTRL_REPEAT) : 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Mode and scan time
    wire        track_en  = ctrl_r[CTRL_TRACK];
    wire        repeat_en = ctrl_r[CTRL_REPEAT];
    wire        enc_mode  = ctrl_r[CTRL_ENC];
    wire        warn_en   = ctrl_r[CTRL_WARN];

    // Width code
    wire [4:0]  den_eff   = (den_r == 5'h00) ? 5'h01 :
                            (den_r > 5'(DEN_MAX)) ? 5'(DEN_MAX) : den_r;
    wire [1:0]  cw        = (den_eff == 5'h01) ? CW_FULL :
                            (den_eff == 5'h02) ? CW_HALF : CW_SMALL;
    wire [15:0] exc_eff   = (exc_r == 16'h0000) ? 16'h0001 : exc_r;
    wire [6:0]  dot_sum   = {1'b0, vd_r} + {5'h00, cw} + 7'h01;
    wire [11:0] dots_den  = dot_sum * {2'h0, den_eff};
    wire [27:0] scan_len  = dots_den * exc_eff;

    // Width setting pads internal scans only; encoder pitch comes from the pulses
    wire [29:0] len30     = {2'h0, scan_len_r};
    wire [29:0] busy_len  = enc_mode ? len30 :
                            len30 + ((cw != CW_SMALL) ? len30 : 30'h0) + ((cw == CW_FULL) ? len30 : 30'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Scan demand and start
    wire        job       = (q_r != 3'h0);
    wire        gap_done  = ~enc_mode & job & ~busy_r & (pend_r == 4'h0) & (gap_cnt_r >= gap_r);
    wire        demand    = job & (enc_mode ? div_bus.pulse : gap_done);
    wire        start     = job & ~busy_r & ((pend_r != 4'h0) | demand);
    wire        scan_end  = busy_r & (busy_cnt_r == 30'h0);
    wire        pend_full = (pend_r == 4'hf);

    // Events and queue
    wire        ev_speed  = warn_en & demand & (busy_r | (pend_r != 4'h0));
    wire        msg_end   = scan_end & last_r;
    wire        q_full    = (q_r == 3'(QUEUE_DEPTH));
    wire        push      = trig_rise & (track_en ? ~q_full : ~job);
    wire        pop       = msg_end & ~(repeat_en & ~track_en);
    wire        ev_ovf    = trig_rise & track_en & q_full;
    wire [2:0]  q_nxt     = q_r + {2'h0, push} - {2'h0, pop};
    wire [2:0]  ev        = {ev_ovf, msg_end, ev_speed};
    wire [2:0]  ist_nxt   = (ist_r & ~(rd_ist ? 3'h7 : 3'h0)) | ev;          // Set wins over read clear

    // Read data mux, unmapped offsets read zero
    wire [31:0] rd_mux =
        (i_avs_address == ADDR_CTRL) ? {28'h0, ctrl_r} :
        (i_avs_address == ADDR_DIV)  ? {24'h0, div_r} :
        (i_avs_address == ADDR_FMT)  ? {19'h0, den_r, 2'h0, vd_r} :
        (i_avs_address == ADDR_EXC)  ? {16'h0, exc_r} :
        (i_avs_address == ADDR_GAP)  ? {16'h0, gap_r} :
        (i_avs_address == ADDR_COLS) ? {24'h0, cols_r} :
        (i_avs_address == ADDR_STAT) ? {12'h0, col_r, 1'b0, q_r, pend_r, 1'b0, busy_r, cw} :
        (i_avs_address == ADDR_IST)  ? {29'h0, ist_r} :
        (i_avs_address == ADDR_IMSK) ? {29'h0, imsk_r} : 32'h0;

    // Every request waits exactly one cycle
    assign o_avs_waitrequest = req & ~ack_r;
    assign o_avs_readdata    = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake and read capture
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r   <= req & ~ack_r;
            rdata_r <= rd_mux;   // Stable at the answering edge since the address is held
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= CTRL_RST;
            div_r  <= DIV_RST;
            vd_r   <= VD_RST;
            den_r  <= DEN_RST;
            exc_r  <= EXC_RST;
            gap_r  <= GAP_RST;
            cols_r <= COLS_RST;
            imsk_r <= IMSK_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= ctrl_w;
            if (wr_div)  div_r  <= div_m[7:0];
            if (wr_fmt) begin
                vd_r  <= fmt_m[FMT_VD_LSB +: 6];
                den_r <= fmt_m[FMT_DEN_LSB +: 5];
            end
            if (wr_exc)  exc_r  <= exc_m[15:0];
            if (wr_gap)  gap_r  <= gap_m[15:0];
            if (wr_cols) cols_r <= cols_m[7:0];
            if (wr_imsk) imsk_r <= imsk_m[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events and interrupt line
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ist_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            ist_r <= ist_nxt;
            irq_r <= |(ist_nxt & imsk_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan pacing: pending demand, busy timer, idle gap
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scan_len_r <= 28'h0;
            pend_r     <= 4'h0;
            busy_r     <= 1'b0;
            busy_cnt_r <= 30'h0;
            gap_cnt_r  <= 16'h0;
            scan_r     <= 1'b0;
        end else begin
            scan_len_r <= scan_len;
            scan_r     <= start;
            // Demand beyond the scan rate piles up here and the print lags
            if (~job) begin
                pend_r <= 4'h0;
            end else if (demand & ~start & ~pend_full) begin
                pend_r <= pend_r + 4'h1;
            end else if (start & ~demand) begin
                pend_r <= pend_r - 4'h1;
            end
            // Busy timer counts out one scan, padded in internal mode
            if (start) begin
                busy_r     <= 1'b1;
                busy_cnt_r <= busy_len - 30'h1;
            end else if (scan_end) begin
                busy_r     <= 1'b0;
            end else if (busy_r) begin
                busy_cnt_r <= busy_cnt_r - 30'h1;
            end
            // Idle gap only runs between internal scans
            if (start | ~job | enc_mode) begin
                gap_cnt_r <= 16'h0;
            end else if (~busy_r & (gap_cnt_r != 16'hffff)) begin
                gap_cnt_r <= gap_cnt_r + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Message columns and print queue
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            col_r      <= 8'h00;
            last_r     <= 1'b0;
            q_r        <= 3'h0;
            printing_r <= 1'b0;
        end else begin
            if (start) begin
                last_r <= (col_r + 8'h01 >= cols_r);
                col_r  <= (col_r + 8'h01 >= cols_r) ? 8'h00 : col_r + 8'h01;
            end else if (msg_end) begin
                last_r <= 1'b0;
            end
            q_r        <= q_nxt;
            printing_r <= (q_nxt != 3'h0);
        end
    end

    // Outputs
    assign o_scan     = scan_r;
    assign o_printing = printing_r;
    assign o_irq      = irq_r;
endmodule

// file: epsc_pkg.sv
// Shared constants for the encoder-paced print scan block
// What this block does
// - Tracking queue keeps up to four pending prints
// - Tracking and repeat printing never active together
// - Encoder mode: one scan per effective pulse
// - Only every nth encoder pulse triggers a scan
// - Encoder pacing only when encoder option selected
// - Character width follows ink drop use ratio
// - Scan time from excitation, dots, width, denominator
// - Excess demand makes scans lag the pulses
// - Demand above scan rate raises speed warning
// - Width setting ignored while encoder pacing used
// - Pitch set purely by travel per pulse
package epsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and link timing
    localparam int CLK_MHZ        = 250;   // Core clock rate
    localparam int ENC_ON_MIN_NS  = 2000;  // Least encoder on time
    localparam int ENC_ON_MIN_CYC = (ENC_ON_MIN_NS * CLK_MHZ + 999) / 1000; // Rounded up
    localparam int SYNC_STAGES    = 3;     // Input filter depth

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [5:0] ADDR_CTRL = 6'h00;   // Mode control
    localparam logic [5:0] ADDR_DIV  = 6'h04;   // Pulse rate division factor
    localparam logic [5:0] ADDR_FMT  = 6'h08;   // Vertical dots and ink drop use
    localparam logic [5:0] ADDR_EXC  = 6'h0c;   // Clock cycles per drop
    localparam logic [5:0] ADDR_GAP  = 6'h10;   // Internal pacing idle cycles
    localparam logic [5:0] ADDR_COLS = 6'h14;   // Scans per message
    localparam logic [5:0] ADDR_STAT = 6'h18;   // Live state, read only
    localparam logic [5:0] ADDR_IST  = 6'h1c;   // Sticky events, clear on read
    localparam logic [5:0] ADDR_IMSK = 6'h20;   // Interrupt mask

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_TRACK  = 0;   // Tracking enable
    localparam int CTRL_REPEAT = 1;   // Repeat print enable
    localparam int CTRL_ENC    = 2;   // Encoder speed matching select
    localparam int CTRL_WARN   = 3;   // Speed matching warning enable
    localparam int FMT_VD_LSB  = 0;   // Vertical dots, six bits
    localparam int FMT_DEN_LSB = 8;   // Ink drop use denominator, five bits
    localparam int IRQ_SPEED   = 0;   // Speed matching error
    localparam int IRQ_DONE    = 1;   // Message finished
    localparam int IRQ_OVF     = 2;   // Trigger lost, queue full

    ////////////////////////////////////////////////////////////////////////////
    // Widths, reset values and encodings
    localparam int DIV_W       = 8;                 // Division factor width
    localparam int QUEUE_DEPTH = 4;                 // Pending prints in tracking
    localparam int DEN_MAX     = 16;                // Smallest drop use is 1/16
    localparam logic [3:0]  CTRL_RST = 4'h0;
    localparam logic [7:0]  DIV_RST  = 8'h01;
    localparam logic [5:0]  VD_RST   = 6'h07;
    localparam logic [4:0]  DEN_RST  = 5'h01;
    localparam logic [15:0] EXC_RST  = 16'h0010;
    localparam logic [15:0] GAP_RST  = 16'h0100;
    localparam logic [7:0]  COLS_RST = 8'h05;
    localparam logic [2:0]  IMSK_RST = 3'h0;
    localparam logic [1:0]  CW_FULL  = 2'h2; // Drop use 1/1
    localparam logic [1:0]  CW_HALF  = 2'h1; // Drop use 1/2
    localparam logic [1:0]  CW_SMALL = 2'h0; // Drop use 1/3 .. 1/16

endpackage

// file: epsc_div_if.sv
// Carrier between the scan engine and the pulse divider
`timescale 1ns/1ps
interface epsc_div_if;
    import epsc_pkg::*;
    logic             tick;    // Qualified encoder edge, one cycle
    logic [DIV_W-1:0] factor;  // Division factor n
    logic             pulse;   // Effective pulse, one cycle
    modport src (output tick, output factor, input pulse);
    modport div (input tick, input factor, output pulse);
endinterface

// file: epsc_sync.sv
// Three stage input synchroniser with agreement filter and rise detect
`timescale 1ns/1ps
module epsc_sync
    import epsc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Raw pin
    input  wire logic i_pin,
    // Filtered result
    output logic      o_level,
    output logic      o_rise
);
    logic [SYNC_STAGES-1:0] sh_r;     // Shift chain, bit 0 is the first stage
    logic                   lvl_r;    // Accepted level
    logic                   rise_r;   // One cycle on accepted rise
    wire                    agree = (sh_r[1] == sh_r[2]);  // Only stages two and three compared

    // Filter needs the pulse high longer than the chain depth
    if (ENC_ON_MIN_CYC <= SYNC_STAGES) begin : g_chk
        $error("Encoder on time too short for input filter");
    end

    // One accepted edge per pulse, however long it stays high
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_r   <= '0;
            lvl_r  <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            sh_r   <= {sh_r[1:0], i_pin};
            if (agree) begin
                lvl_r <= sh_r[2];
            end
            rise_r <= agree & sh_r[2] & ~lvl_r;
        end
    end

    assign o_level = lvl_r;
    assign o_rise  = rise_r;
endmodule

// file: epsc_div.sv
// Encoder pulse rate divider
`timescale 1ns/1ps
module epsc_div
    import epsc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Ticks in, effective pulses out
    epsc_div_if.div   bus
);
    logic [DIV_W-1:0] cnt_r;    // Ticks seen in this group
    logic [DIV_W-1:0] fac_r;    // Factor the count runs against
    logic             pulse_r;  // Effective pulse
    wire  [DIV_W-1:0] eff  = (bus.factor == '0) ? DIV_W'(1) : bus.factor;  // Zero acts as one
    wire              chg  = (bus.factor != fac_r);
    wire              last = (cnt_r == eff - DIV_W'(1));

    // A tick in the cycle of a factor change is dropped, so the new group starts clean
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r   <= '0;
            fac_r   <= DIV_RST;
            pulse_r <= 1'b0;
        end else if (chg) begin
            cnt_r   <= '0;
            fac_r   <= bus.factor;
            pulse_r <= 1'b0;
        end else if (bus.tick) begin
            cnt_r   <= last ? '0 : cnt_r + DIV_W'(1);
            pulse_r <= last;
        end else begin
            pulse_r <= 1'b0;
        end
    end

    assign bus.pulse = pulse_r;
endmodule

// file: epsc_top_asserts.sv
// Port level checks for the print scan block
`timescale 1ns/1ps
module epsc_asserts
    import epsc_pkg::*;
(
    input wire logic        i_clk, i_rst, i_avs_read, i_avs_write,
    input wire logic [5:0]  i_avs_address,
    input wire logic [31:0] i_avs_writedata, o_avs_readdata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic        o_avs_waitrequest, o_scan, o_printing, o_irq
);
    wire        req   = i_avs_read | i_avs_write;        // Any bus request
    wire        ack   = req & ~o_avs_waitrequest;        // Taken at this edge
    wire        rd_ok = i_avs_read & ~o_avs_waitrequest; // Read data valid now
    logic [2:0] msk_r;  // Shadow of the interrupt mask
    logic [2:0] gap_r;  // Cycles since any access to the event or mask register
    ////////////////////////////////////////////////////////////////////////////
    // The irq drops only just after these accesses
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            msk_r <= 3'h0;
            gap_r <= 3'h7;
        end else begin
            if (ack && i_avs_write && i_avs_address == ADDR_IMSK && i_avs_byteenable[0]) msk_r <= i_avs_writedata[2:0];
            if (ack && (i_avs_address == ADDR_IMSK || i_avs_address == ADDR_IST)) gap_r <= 3'h0;
            else if (gap_r != 3'h7) gap_r <= gap_r + 3'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_wait_one_cycle: assert property ($rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("late waitrequest");
    a_unmapped_zero: assert property (rd_ok && i_avs_address > ADDR_IMSK |-> o_avs_readdata == 32'h0)
        else $error("unmapped read");
    a_modes_excl: assert property (rd_ok && i_avs_address == ADDR_CTRL |-> !(o_avs_readdata[0] && o_avs_readdata[1]))
        else $error("both modes set");
    a_width_code: assert property (rd_ok && i_avs_address == ADDR_STAT |-> o_avs_readdata[1:0] != 2'h3)
        else $error("bad width code");
    a_scan_pulse: assert property (o_scan |=> !o_scan)
        else $error("long scan pulse");
    a_scan_in_msg: assert property (o_scan |-> o_printing || $past(o_printing))
        else $error("stray scan");
    a_irq_masked: assert property (msk_r == 3'h0 && $past(msk_r) == 3'h0 |-> !o_irq)
        else $error("masked irq");
    a_irq_drop: assert property ($fell(o_irq) |-> gap_r < 3'h4)
        else $error("irq dropped");
    c_scan: cover property (o_scan);
    c_irq: cover property ($rose(o_irq));
    c_print_end: cover property ($fell(o_printing));
endmodule

// file: epsc_partner.sv
// Behavioural conveyor encoder and target detector
`timescale 1ns/1ps
module epsc_partner #(
    parameter int ON_MIN  = 500,  // Least on level, cycles at 4 ns
    parameter int PER_MIN = 1250  // Least period, cycles at 4 ns
) (
    input  wire logic i_clk,
    output logic      o_enc,
    output logic      o_trig
);
    initial {o_enc, o_trig} = 2'b00;
    ////////////////////////////////////////////////////////////////////////////
    // One encoder pulse, stretched or trimmed to a legal shape
    task automatic enc_pulse(input int on_c, input int per_c);
        int on_l, per_l;
        per_l = (per_c < PER_MIN) ? PER_MIN : per_c;
        on_l  = (on_c < ON_MIN) ? ON_MIN : on_c;
        if (on_l * 10 < per_l * 3) on_l = (per_l * 3 + 9) / 10;
        if (on_l * 10 > per_l * 7) on_l = per_l * 7 / 10;
        @(posedge i_clk) o_enc <= 1'b1;
        repeat (on_l) @(posedge i_clk);
        o_enc <= 1'b0;
        repeat (per_l - on_l - 1) @(posedge i_clk);
    endtask
    // Detector sees one target
    task automatic trig_pulse();
        @(posedge i_clk) o_trig <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_trig <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

// file: test_encoder_speed_matched_print_scan.sv
// Self-checking bench for the print scan block
`timescale 1ns/1ps
module test_encoder_speed_matched_print_scan;
    import epsc_pkg::*;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [5:0]  i_avs_address = 6'h0;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic        o_avs_waitrequest, o_scan, o_printing, o_irq, i_enc, i_trig;
    int          n_errors = 0, total_checks = 0, n_scan = 0;
    always #2 i_clk = ~i_clk;
    // Scans seen
    always @(posedge i_clk) if (o_scan === 1'b1) n_scan <= n_scan + 1;
    epsc_top u_epsc_top (.*);
    epsc_partner u_epsc_partner (.i_clk, .o_enc(i_enc), .o_trig(i_trig));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus access, held until waitrequest drops
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        q = o_avs_readdata;
        if (o_avs_waitrequest !== 1'b0) chk("waitrequest", 32'h1, 32'h0);
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask
    task automatic setup(input logic [31:0] c, f, e, n, m);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        wr(ADDR_FMT, f);
        wr(ADDR_EXC, e);
        wr(ADDR_COLS, n);
        wr(ADDR_GAP, 32'h4);
        wr(ADDR_IMSK, m);
        wr(ADDR_CTRL, c);
    endtask
    task automatic pulses(input int k, input int per);
        repeat (k) u_epsc_partner.enc_pulse(per / 2, per);
    endtask
    // Wait for the message to end, then let irq settle
    task automatic wait_idle(input int lim);
        int n = 0;
        while (o_printing !== 1'b0 && n < lim) begin
            @(posedge i_clk);
            n++;
        end
        chk("printing", 32'(o_printing), 32'h0);
        repeat (3) @(posedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        logic [4:0] den [4] = '{5'd1, 5'd2, 5'd3, 5'd16};
        setup(32'h0, 32'h107, 32'h10, 32'h5, 32'h0);
        rc("div", ADDR_DIV, 32'h1);
        rc("gap", ADDR_GAP, 32'h4);
        wr(6'h24, 32'hffff_ffff);
        rc("unmapped", 6'h24, 32'h0);
        wr(ADDR_CTRL, 32'h3);
        rc("ctrl", ADDR_CTRL, 32'h1);
        foreach (den[i]) begin
            wr(ADDR_FMT, {19'h0, den[i], 8'h07});
            bus(1'b0, ADDR_STAT, 32'h0, q);
            chk("width", {30'h0, q[1:0]}, {30'h0, den[i] == 5'd1 ? CW_FULL : den[i] == 5'd2 ? CW_HALF : CW_SMALL});
        end
        $display("test regs done");
    endtask
    // Encoder pacing: divide by 3, then 4, then 1
    task automatic t_enc();
        int s;
        setup(32'h4, 32'h100, 32'h1, 32'h4, 32'h2);
        s = n_scan;
        pulses(1, 1250);
        chk("idle scans", n_scan - s, 32'h0);
        wr(ADDR_DIV, 32'h3);
        u_epsc_partner.trig_pulse();
        pulses(8, 1250);
        chk("div3 scans", n_scan - s, 32'h2);
        wr(ADDR_DIV, 32'h4);
        pulses(2, 2000);
        chk("cleared div", n_scan - s, 32'h2);
        pulses(2, 1250);
        chk("div4 scans", n_scan - s, 32'h3);
        wr(ADDR_DIV, 32'h1);
        pulses(1, 1250);
        wait_idle(200);
        chk("enc scans", n_scan - s, 32'h4);
        chk("irq up", 32'(o_irq), 32'h1);
        rc("events", ADDR_IST, 32'h2);
        repeat (4) @(posedge i_clk);
        chk("irq down", 32'(o_irq), 32'h0);
        $display("test encoder done");
    endtask
    // Internal pacing, done event masked
    task automatic t_int();
        int s;
        setup(32'h0, 32'h100, 32'h1, 32'h3, 32'h0);
        s = n_scan;
        u_epsc_partner.trig_pulse();
        wait_idle(2000);
        chk("int scans", n_scan - s, 32'h3);
        chk("masked irq", 32'(o_irq), 32'h0);
        $display("test internal done");
    endtask
    // Demand above a 4096 cycle scan: warning, lag
    task automatic t_warn();
        int s;
        setup(32'hc, 32'h1007, 32'h20, 32'h2, 32'h1);
        s = n_scan;
        u_epsc_partner.trig_pulse();
        pulses(2, 1250);
        repeat (3) @(posedge i_clk);
        chk("warn irq", 32'(o_irq), 32'h1);
        rc("speed error", ADDR_IST, 32'h1);
        wait_idle(10000);
        chk("lag scans", n_scan - s, 32'h2);
        $display("test warning done");
    endtask
    // Five targets in one long print: four held
    task automatic t_track();
        int s;
        logic [31:0] q;
        setup(32'h1, 32'h1007, 32'h8, 32'h1, 32'h4);
        s = n_scan;
        repeat (5) u_epsc_partner.trig_pulse();
        bus(1'b0, ADDR_STAT, 32'h0, q);
        chk("queue", {29'h0, q[10:8]}, 32'h4);
        rc("lost", ADDR_IST, 32'h4);
        wait_idle(8000);
        chk("track scans", n_scan - s, 32'h4);
        $display("test tracking done");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        t_regs();
        t_enc();
        t_int();
        t_warn();
        t_track();
        end_sim();
    end
    // Watchdog, nearly three times the expected run
    initial begin
        repeat (90000) @(posedge i_clk);
        n_errors++;
        end_sim();
    end
endmodule
bind epsc_top epsc_asserts u_epsc_asserts (.*);
